// [verilog/bridge_pkg.sv]
// shared constants, types and carriers of the processor to register bridge
package bridge_pkg;

  // -------------------------------------------------------------------------
  // data path widths
  // -------------------------------------------------------------------------
  localparam int DATA_W = 32;  // register side matches the processor bus
  localparam int LANE_W = DATA_W / 8;
  localparam int INDEX_W = 16;  // word index width, plain default

  // -------------------------------------------------------------------------
  // values after reset
  // -------------------------------------------------------------------------
  localparam logic RST_HOLD = 1'b1;  // bus held off while in reset
  localparam logic RST_TOGGLE = 1'b0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [LANE_W-1:0] RST_LANES = 4'h0;
  localparam logic [INDEX_W-1:0] RST_INDEX = 16'h0000;

  // one captured transfer, held stable while it crosses domains
  typedef struct packed {
    logic is_write;
    logic [INDEX_W-1:0] index;
    logic [DATA_W-1:0] word;
    logic [LANE_W-1:0] lanes;
  } reg_cmd_t;

  localparam reg_cmd_t RST_CMD = '{
    is_write: 1'b0,
    index: RST_INDEX,
    word: RST_WORD,
    lanes: RST_LANES
  };

endpackage

// [verilog/sync_bit.sv]
// two flip-flop synchroniser for one level or toggle
`timescale 1ns/1ns

module sync_bit (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_arst_n,
  // level from the far domain
  input wire logic i_async,
  // level safe to use in this domain
  output logic o_sync
);

  logic meta;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// [verilog/crossing_bridge_unit.sv]
// processor bus slave to simple register interface bridge across two clocks
`timescale 1ns/1ns

module crossing_bridge_unit (
  // processor domain clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // processor bus slave port
  input wire logic [bridge_pkg::INDEX_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic i_avs_read,
  input wire logic [bridge_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [bridge_pkg::LANE_W-1:0] i_avs_byteenable,
  output logic [bridge_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_bus_hold_req,
  // user domain clock
  input wire logic i_user_clk,
  // register side interface
  output logic o_reg_write_strobe,
  output logic o_reg_read_req,
  output logic [bridge_pkg::INDEX_W-1:0] o_reg_word_index,
  output logic [bridge_pkg::DATA_W-1:0] o_reg_write_word,
  output logic [bridge_pkg::LANE_W-1:0] o_reg_lane_strobes,
  input wire logic [bridge_pkg::DATA_W-1:0] i_reg_read_word,
  input wire logic i_reg_read_ack
);

  // -------------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_BUSY, C_DONE} cpu_state_t;
  typedef enum logic {U_IDLE, U_READ} user_state_t;

  cpu_state_t cpu_state;
  user_state_t user_state;
  bridge_pkg::reg_cmd_t cmd;  // processor domain, stable while busy
  logic req_tgl;  // processor domain event toward user side
  logic ack_tgl;  // user domain event toward processor side
  logic req_sync;
  logic ack_sync;
  logic req_seen;
  logic ack_seen;
  logic new_req;
  logic ack_event;
  logic [bridge_pkg::DATA_W-1:0] rd_hold;  // user domain, stable on ack

  // -------------------------------------------------------------------------
  // clock domain crossing
  // -------------------------------------------------------------------------
  // toggle handshake crossing
  // each direction is a single toggle; the payload is held still until
  // the toggle has crossed, so the wide words need no synchroniser
  sync_bit u_req_sync (
    .i_clk(i_user_clk),
    .i_arst_n(i_arst_n),
    .i_async(req_tgl),
    .o_sync(req_sync)
  );

  sync_bit u_ack_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async(ack_tgl),
    .o_sync(ack_sync)
  );

  // edge of a synchronised toggle marks one event
  assign new_req = req_sync ^ req_seen;
  assign ack_event = ack_sync ^ ack_seen;

  // -------------------------------------------------------------------------
  // processor side flow control
  // -------------------------------------------------------------------------
  // one transfer at a time
  // requests are taken only in idle; a write wins if both are asserted
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cpu_state <= C_IDLE;
      req_tgl <= bridge_pkg::RST_TOGGLE;
      ack_seen <= bridge_pkg::RST_TOGGLE;
    end else begin
      case (cpu_state)
        C_IDLE: begin
          if (i_avs_write || i_avs_read) begin
            req_tgl <= ~req_tgl;
            cpu_state <= C_BUSY;
          end
        end
        C_BUSY: begin
          if (ack_event) begin
            ack_seen <= ack_sync;
            cpu_state <= C_DONE;
          end
        end
        C_DONE: begin
          cpu_state <= C_IDLE;
        end
        default: begin
          cpu_state <= C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd <= bridge_pkg::RST_CMD;
    end else if (cpu_state == C_IDLE && (i_avs_write || i_avs_read)) begin
      cmd.is_write <= i_avs_write;
      cmd.index <= i_avs_address;
      cmd.word <= i_avs_writedata;
      cmd.lanes <= i_avs_byteenable;
    end
  end

  // release for one cycle at completion
  // idle also holds, so the completing cycle is the only low one; this
  // costs one cycle per access but keeps the answer fully registered
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bus_hold_req <= bridge_pkg::RST_HOLD;
    end else begin
      o_bus_hold_req <= !(cpu_state == C_BUSY && ack_event);
    end
  end

  // hand the read word to the bus
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= bridge_pkg::RST_WORD;
    end else if (cpu_state == C_BUSY && ack_event && !cmd.is_write) begin
      o_avs_readdata <= rd_hold;
    end
  end

  // -------------------------------------------------------------------------
  // register side sequencing
  // -------------------------------------------------------------------------
  // user side serves one command at a time
  always_ff @(posedge i_user_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      user_state <= U_IDLE;
      req_seen <= bridge_pkg::RST_TOGGLE;
      ack_tgl <= bridge_pkg::RST_TOGGLE;
    end else begin
      case (user_state)
        U_IDLE: begin
          if (new_req) begin
            req_seen <= req_sync;
            if (cmd.is_write) begin
              ack_tgl <= ~ack_tgl;  // write is done once issued
            end else begin
              user_state <= U_READ;
            end
          end
        end
        U_READ: begin
          // the slave answers every read exactly once
          if (i_reg_read_ack) begin
            ack_tgl <= ~ack_tgl;
            user_state <= U_IDLE;
          end
        end
        default: begin
          user_state <= U_IDLE;
        end
      endcase
    end
  end

  // strobe with index, word and lanes
  // only one of the two pulses per command
  always_ff @(posedge i_user_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_write_strobe <= 1'b0;
      o_reg_read_req <= 1'b0;
      o_reg_word_index <= bridge_pkg::RST_INDEX;
      o_reg_write_word <= bridge_pkg::RST_WORD;
      o_reg_lane_strobes <= bridge_pkg::RST_LANES;
    end else begin
      o_reg_write_strobe <= user_state == U_IDLE && new_req && cmd.is_write;
      o_reg_read_req <= user_state == U_IDLE && new_req && !cmd.is_write;
      if (user_state == U_IDLE && new_req) begin
        o_reg_word_index <= cmd.index;
        o_reg_write_word <= cmd.word;
        // lane bit n covers byte n
        o_reg_lane_strobes <= cmd.lanes;
      end
    end
  end

  // word is valid in the acknowledge cycle
  always_ff @(posedge i_user_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_hold <= bridge_pkg::RST_WORD;
    end else if (user_state == U_READ && i_reg_read_ack) begin
      rd_hold <= i_reg_read_word;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  AST_ONE_CMD: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    new_req |-> user_state == U_IDLE
  ) else $error("new command while the previous one is pending");

  AST_HOLD_BUSY: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cpu_state == C_IDLE && (i_avs_write || i_avs_read))
      |=> o_bus_hold_req throughout (cpu_state == C_BUSY)[*2]
  ) else $error("hold request dropped while a transfer is pending");

  AST_WR_CAPTURE: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cpu_state == C_IDLE && i_avs_write)
      |=> cmd.is_write && cmd.word == $past(i_avs_writedata)
  ) else $error("write data not captured");

  AST_RD_ISSUE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    (new_req && !cmd.is_write) |=> o_reg_read_req && user_state == U_READ
  ) else $error("read not issued on the register side");

  AST_STABLE_CMD: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cpu_state == C_BUSY) |=> $stable(cmd) && $stable(req_tgl)
  ) else $error("command changed while crossing");

  AST_NO_COLLIDE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    !(o_reg_write_strobe && o_reg_read_req)
  ) else $error("write strobe and read request together");

  AST_WR_STROBE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    (new_req && cmd.is_write) |=> o_reg_write_strobe
      && o_reg_write_word == cmd.word && o_reg_word_index == cmd.index
      ##1 !o_reg_write_strobe
  ) else $error("write strobe not a single pulse with its data");

  AST_LANES: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    o_reg_write_strobe |-> o_reg_lane_strobes == cmd.lanes
  ) else $error("lane strobes do not match the bus byte enables");

  AST_RD_PULSE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    o_reg_read_req |-> o_reg_word_index == cmd.index ##1 !o_reg_read_req
  ) else $error("read request not a single pulse with its index");

  AST_RD_RETURN: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cpu_state == C_BUSY && ack_event && !cmd.is_write)
      |=> o_avs_readdata == rd_hold && !o_bus_hold_req
  ) else $error("read word not returned on completion");

  AST_RELEASE: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (cpu_state == C_BUSY && ack_event) |=> !o_bus_hold_req ##1 o_bus_hold_req
  ) else $error("hold request not released for exactly one cycle");

  AST_BUSY_HOLDS: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    cpu_state == C_BUSY |-> o_bus_hold_req
  ) else $error("hold request low while a transfer is pending");

  AST_ONE_ISSUE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    (o_reg_write_strobe || o_reg_read_req)
      |=> !o_reg_write_strobe && !o_reg_read_req
  ) else $error("two register commands issued back to back");

  AST_RD_CAPTURE: assert property (
    @(posedge i_user_clk) disable iff (!i_arst_n)
    (user_state == U_READ && i_reg_read_ack)
      |=> rd_hold == $past(i_reg_read_word)
  ) else $error("read word not captured with its acknowledge");

  AST_DONE_RELEASE: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    cpu_state == C_DONE |-> !o_bus_hold_req
  ) else $error("hold request high in the completing cycle");

endmodule

// [tb/register_file_slave.sv]
// register slave model that answers each read request after a short delay
`timescale 1ns/1ns

module register_file_slave (
  // user clock and reset
  input wire logic i_user_clk,
  input wire logic i_arst_n,
  // request side
  input wire logic i_read_req,
  input wire logic [bridge_pkg::INDEX_W-1:0] i_word_index,
  // answer side
  output logic [bridge_pkg::DATA_W-1:0] o_read_word,
  output logic o_read_ack
);
  logic [bridge_pkg::INDEX_W-1:0] idx;
  logic [1:0] wait_cnt;
  logic busy;
  logic [bridge_pkg::DATA_W-1:0] junk;

  // -------------------------------------------------------------------------
  // read answer
  // -------------------------------------------------------------------------
  // one word per request
  always_ff @(posedge i_user_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
      idx <= 16'h0000;
      wait_cnt <= 2'h0;
      o_read_ack <= 1'b0;
    end else begin
      o_read_ack <= 1'b0;
      if (i_read_req) begin
        busy <= 1'b1;
        idx <= i_word_index;
        wait_cnt <= i_word_index[1:0];  // prompt or slow answers
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (busy) begin
        busy <= 1'b0;
        o_read_ack <= 1'b1;
      end
    end
  end

  // changing filler so a stale word can never pass for an answer
  always_ff @(posedge i_user_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      junk <= 32'h5a5a_c3c3;
    end else begin
      junk <= {junk[30:0], ~junk[31]};
    end
  end

  assign o_read_word = o_read_ack ? {idx, ~idx} : junk;
endmodule

// [tb/test_crossing_bridge_unit.sv]
// self-checking bench of the processor to register bridge
`timescale 1ns/1ns

module test_crossing_bridge_unit;
  logic i_core_clk = 1'b0;
  logic i_user_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [bridge_pkg::INDEX_W-1:0] i_avs_address = 16'h0000;
  logic i_avs_write = 1'b0;
  logic i_avs_read = 1'b0;
  logic [bridge_pkg::DATA_W-1:0] i_avs_writedata = 32'h0000_0000;
  logic [bridge_pkg::LANE_W-1:0] i_avs_byteenable = 4'h0;
  logic [bridge_pkg::DATA_W-1:0] o_avs_readdata, rd_word, wr_word;
  logic o_bus_hold_req, wr_strobe, rd_req, rd_ack;
  logic [bridge_pkg::INDEX_W-1:0] word_index;
  logic [bridge_pkg::LANE_W-1:0] lanes;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000_3c34;
  bridge_pkg::reg_cmd_t reg_q[$];
  bridge_pkg::reg_cmd_t exp_cmd;
  logic [bridge_pkg::INDEX_W:0] exp_rd;
  logic [bridge_pkg::DATA_W:0] bus_q[$];
  logic [bridge_pkg::DATA_W:0] bus_exp;

  // unrelated clocks: 8 ns core, 10 ns user
  always #4 i_core_clk = ~i_core_clk;
  always #5 i_user_clk = ~i_user_clk;

  crossing_bridge_unit DUT (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
    .i_avs_read(i_avs_read), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_bus_hold_req(o_bus_hold_req), .i_user_clk(i_user_clk),
    .o_reg_write_strobe(wr_strobe), .o_reg_read_req(rd_req),
    .o_reg_word_index(word_index), .o_reg_write_word(wr_word),
    .o_reg_lane_strobes(lanes), .i_reg_read_word(rd_word),
    .i_reg_read_ack(rd_ack)
  );

  register_file_slave slave (
    .i_user_clk(i_user_clk), .i_arst_n(i_arst_n), .i_read_req(rd_req),
    .i_word_index(word_index), .o_read_word(rd_word), .o_read_ack(rd_ack)
  );

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one access; the request holds until hold drops, both write and read
  // high at once is the awkward case and must act as a plain write
  task automatic bus_access();
    logic [31:0] r;
    logic wr;
    int n;
    bridge_pkg::reg_cmd_t note;
    r = next_rand();
    wr = r[21:20] != 2'h0;
    @(negedge i_core_clk);
    i_avs_address = r[15:0];
    i_avs_writedata = next_rand();
    i_avs_byteenable = r[19:16];
    i_avs_write = wr;
    i_avs_read = r[21:20] == 2'h0 || r[21:20] == 2'h3;
    note.is_write = wr;
    note.index = r[15:0];
    note.word = wr ? i_avs_writedata : 32'h0000_0000;
    note.lanes = wr ? r[19:16] : 4'h0;
    reg_q.push_back(note);
    bus_q.push_back({~wr, wr ? 32'h0 : {r[15:0], ~r[15:0]}});
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_bus_hold_req !== 1'b0 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  // -------------------------------------------------------------------------
  // register side watcher
  // -------------------------------------------------------------------------
  always @(negedge i_user_clk) begin
    if (wr_strobe === 1'b1 || rd_req === 1'b1) begin
      check("strobe and req", wr_strobe & rd_req, 1'b0);
      if (reg_q.size() == 0) begin
        check("unexpected command", 1'b1, 1'b0);
      end else begin
        exp_cmd = reg_q.pop_front();
        if (rd_req === 1'b1) begin
          exp_rd = {exp_cmd.is_write, exp_cmd.index};
          check("read index", {1'b0, word_index}, exp_rd);
        end else begin
          check("wr cmd", {1'b1, word_index, wr_word, lanes}, exp_cmd);
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // bus side watcher: one completion per access, read word on completion
  // -------------------------------------------------------------------------
  always @(negedge i_core_clk) begin
    if (i_arst_n === 1'b1 && o_bus_hold_req === 1'b0) begin
      check("issued before release", reg_q.size(), 0);
      if (bus_q.size() == 0) begin
        check("extra completion", 1'b1, 1'b0);
      end else begin
        bus_exp = bus_q.pop_front();
        if (bus_exp[32]) begin
          check("read data", o_avs_readdata, bus_exp[31:0]);
        end
      end
    end
  end

  initial begin
    repeat (12) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("hold in reset", o_bus_hold_req, bridge_pkg::RST_HOLD);
    i_arst_n = 1'b1;
    repeat (60) bus_access();
    @(negedge i_core_clk);
    i_avs_write = 1'b0;
    i_avs_read = 1'b0;
    repeat (40) @(negedge i_core_clk);
    check("left over", reg_q.size() + bus_q.size(), 0);
    end_of_test();
  end
endmodule
